// [src/bip_pkg.sv]
package bip_pkg;

  // Register port geometry
  localparam int unsigned BIP_ADDR_W = 8;
  localparam int unsigned BIP_DATA_W = 32;

  // Register offsets
  localparam logic [7:0] BIP_OFF_CTRL0 = 8'h00;
  localparam logic [7:0] BIP_OFF_CTRL1 = 8'h04;
  localparam logic [7:0] BIP_OFF_VBASE = 8'h08;
  localparam logic [7:0] BIP_OFF_STATUS = 8'h0c;
  localparam logic [7:0] BIP_OFF_PEND = 8'h10;
  localparam logic [7:0] BIP_OFF_TCTL = 8'h14;
  localparam logic [7:0] BIP_OFF_TLOAD = 8'h18;
  localparam logic [7:0] BIP_TLOAD_STEP = 8'h04;

  // interrupt_control_zero fields
  localparam int unsigned BIP_C0_TICK = 0;
  localparam int unsigned BIP_C0_SUB_EDGE = 1;
  localparam int unsigned BIP_C0_SUB_LVL = 2;
  localparam int unsigned BIP_C0_SERIAL = 3;
  localparam int unsigned BIP_C0_TMR = 4;
  localparam int unsigned BIP_C0_BUS = 8;
  localparam int unsigned BIP_C0_W = 15;

  // interrupt_control_one fields
  localparam int unsigned BIP_C1_PFAIL = 0;
  localparam int unsigned BIP_C1_ABORT = 1;
  localparam int unsigned BIP_C1_PARITY = 2;
  localparam int unsigned BIP_C1_GLOBAL = 3;
  localparam int unsigned BIP_C1_TICK_HI = 4;
  localparam int unsigned BIP_C1_W = 5;

  // Status fields, write one to clear
  localparam int unsigned BIP_ST_PARITY = 0;
  localparam int unsigned BIP_ST_TMR = 1;
  localparam int unsigned BIP_ST_W = 4;

  // Reset values
  localparam logic [BIP_C0_W-1:0] BIP_CTRL0_RST = 15'h0000;
  localparam logic [BIP_C1_W-1:0] BIP_CTRL1_RST = 5'h00;
  localparam logic [3:0] BIP_VBASE_RST = 4'h0;

  // Timers
  localparam int unsigned BIP_TMR_NUM = 3;
  localparam int unsigned BIP_TMR_W = 24;
  localparam int unsigned BIP_TMR_PRESCALE = 16;

  // Synchronised pin vector layout
  localparam int unsigned BIP_PIN_PFAIL = 0;
  localparam int unsigned BIP_PIN_ABORT = 1;
  localparam int unsigned BIP_PIN_PARITY = 2;
  localparam int unsigned BIP_PIN_TICK = 3;
  localparam int unsigned BIP_PIN_SUB = 4;
  localparam int unsigned BIP_PIN_SERIAL = 5;
  localparam int unsigned BIP_PIN_BUS = 6;
  localparam int unsigned BIP_PIN_W = 13;
  localparam logic [BIP_PIN_W-1:0] BIP_PIN_RST = 13'h1ffb;

  // Priority grid: seven levels by six groups
  localparam int unsigned BIP_LEVELS = 7;
  localparam int unsigned BIP_GROUPS = 6;
  localparam int unsigned BIP_SLOTS = 42;

  function automatic int bip_slot(input int lvl, input int grp);
    return (lvl - 1) * BIP_GROUPS + (grp - 1);
  endfunction

  localparam int BIP_S_PFAIL = bip_slot(7, 6);
  localparam int BIP_S_ABORT = bip_slot(7, 5);
  localparam int BIP_S_PARITY = bip_slot(7, 4);
  localparam int BIP_S_TMR0 = bip_slot(7, 3);
  localparam int BIP_S_TMR1 = bip_slot(6, 3);
  localparam int BIP_S_TMR2 = bip_slot(5, 3);
  localparam int BIP_S_SUB_EDGE = bip_slot(6, 4);
  localparam int BIP_S_TICK_HI = bip_slot(6, 2);
  localparam int BIP_S_TICK_LO = bip_slot(3, 2);
  localparam int BIP_S_SERIAL = bip_slot(5, 2);
  localparam int BIP_S_SUB_LVL = bip_slot(4, 2);

  // Hardware part of each vector
  localparam logic [3:0] BIP_VN_PFAIL = 4'hb;
  localparam logic [3:0] BIP_VN_ABORT = 4'ha;
  localparam logic [3:0] BIP_VN_PARITY = 4'h8;
  localparam logic [3:0] BIP_VN_TMR0 = 4'h0;
  localparam logic [3:0] BIP_VN_TMR1 = 4'h1;
  localparam logic [3:0] BIP_VN_TMR2 = 4'h2;
  localparam logic [3:0] BIP_VN_TICK_HI = 4'h5;
  localparam logic [3:0] BIP_VN_TICK_LO = 4'h7;
  localparam logic [3:0] BIP_VN_SUB_EDGE = 4'h3;
  localparam logic [3:0] BIP_VN_SPURIOUS = 4'hf;

endpackage

// [src/bip_sync.sv]
`timescale 1ns/1ns
// Two-stage synchroniser for asynchronous pins
module bip_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // First stage feeds only the second
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      meta_r <= RESET_VAL;
      sync_r <= RESET_VAL;
    end
    else
    begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule

// [src/bip_timer.sv]
`timescale 1ns/1ns
// Down-counter with fixed prescaler and automatic reload
module bip_timer #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned PRESCALE = 16
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic [WIDTH-1:0] load_in,
  output logic timeout_out
);

  localparam int unsigned PRE_W = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRESCALE - 1);

  logic [PRE_W-1:0] pre_r;
  logic [WIDTH-1:0] count_r;
  logic timeout_r;
  wire pre_tick = enable_in && (pre_r == PRE_LAST);
  wire at_zero = (count_r == '0);

  // Prescaler, counter and time-out pulse
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      pre_r <= '0;
      count_r <= '0;
      timeout_r <= 1'b0;
    end
    else if (!enable_in)
    begin
      pre_r <= '0;
      count_r <= load_in; // Stopped timer holds its preload
      timeout_r <= 1'b0;
    end
    else
    begin
      pre_r <= pre_tick ? '0 : pre_r + 1'b1;
      timeout_r <= pre_tick && at_zero;
      if (pre_tick)
      begin
        count_r <= at_zero ? load_in : count_r - 1'b1;
      end
    end
  end

  assign timeout_out = timeout_r;

endmodule

// [src/bip_prioritizer.sv]
`timescale 1ns/1ns
// What this block does
// - Take eighteen requests, rank them in seven levels of six groups.
// - Higher level beats lower; within a level higher group wins.
// - Vector is software upper nibble plus per-source hardware nibble.
// - One global mask bit blocks every request together.
// - Requests are edge latched except serial, subsystem level and bus lines.
// - Unmasked power fail gives level 7 group 6, nibble B, cleared by ack.
// - Unmasked abort edge gives level 7 group 5, nibble A, ack clears.
// - Parity error gives level 7 group 4 with nibble 8.
// - Parity status latches regardless of enable until software writes one.
// - Falling tick edge latched; level 6 nibble 5 or level 3 nibble 7.
// - Subsystem line feeds level 6 group 4 edge and level 4 group 2 level.
// - Timers request levels 7, 6, 5 in group 3, nibbles 0, 1, 2.
// - Timers are 24 bits, counting at the clock divided by sixteen.
// - Timer time-out sets status bit, cleared by writing one.
// - Own vector for all but bus, serial and subsystem level sources.
// - Serial request is one level input; the serial part supplies vector.
module bip_prioritizer
  import bip_pkg::*;
#(
  parameter int unsigned TMR_PRESCALE = BIP_TMR_PRESCALE
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [BIP_ADDR_W-1:0] reg_addr_in,
  input wire logic [BIP_DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [BIP_DATA_W-1:0] reg_rdata_out,
  input wire logic power_fail_n_in,
  input wire logic abort_n_in,
  input wire logic parity_error_request_in,
  input wire logic serial_output_bit_three_in,
  input wire logic subsystem_bus_request_n_in,
  input wire logic serial_controller_request_n_in,
  input wire logic [BIP_LEVELS-1:0] bus_interrupt_n_in,
  input wire logic iack_in,
  input wire logic [2:0] iack_level_in,
  output logic [2:0] ipl_out,
  output logic [7:0] vector_out,
  output logic vector_valid_out,
  output logic vector_external_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Highest set slot index
  function automatic logic [5:0] top_slot(input logic [BIP_SLOTS-1:0] req);
    top_slot = '0;
    for (int i = 0; i < BIP_SLOTS; i++)
    begin
      if (req[i])
      begin
        top_slot = 6'(i);
      end
    end
  endfunction

  // Slots belonging to one level
  function automatic logic [BIP_SLOTS-1:0] level_mask(input logic [2:0] lvl);
    level_mask = '0;
    for (int i = 0; i < BIP_SLOTS; i++)
    begin
      level_mask[i] = ((i / BIP_GROUPS) + 1 == int'(lvl));
    end
  endfunction

  // Level of a slot
  function automatic logic [2:0] slot_level(input logic [5:0] slot);
    return 3'((int'(slot) / BIP_GROUPS) + 1);
  endfunction

  // Hardware vector nibble per slot
  function automatic logic [3:0] slot_nibble(input logic [5:0] slot);
    case (int'(slot))
      BIP_S_PFAIL: slot_nibble = BIP_VN_PFAIL;
      BIP_S_ABORT: slot_nibble = BIP_VN_ABORT;
      BIP_S_PARITY: slot_nibble = BIP_VN_PARITY;
      BIP_S_TMR0: slot_nibble = BIP_VN_TMR0;
      BIP_S_TMR1: slot_nibble = BIP_VN_TMR1;
      BIP_S_TMR2: slot_nibble = BIP_VN_TMR2;
      BIP_S_TICK_HI: slot_nibble = BIP_VN_TICK_HI;
      BIP_S_TICK_LO: slot_nibble = BIP_VN_TICK_LO;
      BIP_S_SUB_EDGE: slot_nibble = BIP_VN_SUB_EDGE;
      default: slot_nibble = BIP_VN_SPURIOUS;
    endcase
  endfunction

  // Sources whose vector comes from elsewhere
  function automatic logic slot_external(input logic [5:0] slot);
    return (int'(slot) % BIP_GROUPS == 0) || (int'(slot) == BIP_S_SERIAL) ||
           (int'(slot) == BIP_S_SUB_LVL);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pins

  logic [BIP_PIN_W-1:0] pin_sync;
  logic [BIP_PIN_W-1:0] pin_prev_r;

  bip_sync #(
    .WIDTH(BIP_PIN_W),
    .RESET_VAL(BIP_PIN_RST)
  ) u_sync (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .async_in({bus_interrupt_n_in, serial_controller_request_n_in,
               subsystem_bus_request_n_in, serial_output_bit_three_in,
               parity_error_request_in, abort_n_in, power_fail_n_in}),
    .sync_out(pin_sync)
  );

  // Edge events on synchronised pins
  wire pfail_edge = pin_prev_r[BIP_PIN_PFAIL] && !pin_sync[BIP_PIN_PFAIL];
  wire abort_edge = pin_prev_r[BIP_PIN_ABORT] && !pin_sync[BIP_PIN_ABORT];
  wire parity_edge = !pin_prev_r[BIP_PIN_PARITY] &&
                     pin_sync[BIP_PIN_PARITY];
  wire tick_edge = pin_prev_r[BIP_PIN_TICK] && !pin_sync[BIP_PIN_TICK];
  wire sub_edge = pin_prev_r[BIP_PIN_SUB] && !pin_sync[BIP_PIN_SUB];
  wire sub_level = !pin_sync[BIP_PIN_SUB];
  wire serial_level = !pin_sync[BIP_PIN_SERIAL];
  wire [BIP_LEVELS-1:0] bus_level = ~pin_sync[BIP_PIN_BUS +: BIP_LEVELS];

  ////////////////////////////////////////////////////////////////////////////
  // Registers and decode

  logic [BIP_C0_W-1:0] ctrl0_r;
  logic [BIP_C1_W-1:0] ctrl1_r;
  logic [3:0] vbase_r;
  logic [BIP_ST_W-1:0] status_r;
  logic [BIP_TMR_NUM-1:0] tctl_r;
  logic [BIP_TMR_W-1:0] tload_r [BIP_TMR_NUM];
  logic [BIP_TMR_NUM-1:0] tmr_timeout;
  logic [BIP_DATA_W-1:0] rdata_r;

  wire wr_ctrl0 = reg_wr_in && (reg_addr_in == BIP_OFF_CTRL0);
  wire wr_ctrl1 = reg_wr_in && (reg_addr_in == BIP_OFF_CTRL1);
  wire wr_vbase = reg_wr_in && (reg_addr_in == BIP_OFF_VBASE);
  wire wr_status = reg_wr_in && (reg_addr_in == BIP_OFF_STATUS);
  wire wr_tctl = reg_wr_in && (reg_addr_in == BIP_OFF_TCTL);
  wire global_en = ctrl1_r[BIP_C1_GLOBAL];
  wire tick_hi = ctrl1_r[BIP_C1_TICK_HI];

  // Status set events: parity edge and timer time-outs
  wire [BIP_ST_W-1:0] status_set = {tmr_timeout, parity_edge};
  wire [BIP_ST_W-1:0] status_clr = wr_status ?
                                   reg_wdata_in[BIP_ST_W-1:0] : '0;
  wire [BIP_ST_W-1:0] status_nxt = status_set |
                                   (status_r & ~status_clr);

  // Control and status registers
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      ctrl0_r <= BIP_CTRL0_RST;
      ctrl1_r <= BIP_CTRL1_RST;
      vbase_r <= BIP_VBASE_RST;
      status_r <= '0;
      tctl_r <= '0;
    end
    else
    begin
      if (wr_ctrl0) ctrl0_r <= reg_wdata_in[BIP_C0_W-1:0];
      if (wr_ctrl1) ctrl1_r <= reg_wdata_in[BIP_C1_W-1:0];
      if (wr_vbase) vbase_r <= reg_wdata_in[3:0];
      if (wr_tctl) tctl_r <= reg_wdata_in[BIP_TMR_NUM-1:0];
      status_r <= status_nxt;
    end
  end

  // Timers with their preload registers
  wire [BIP_TMR_W-1:0] tload_rd [BIP_TMR_NUM];
  genvar t;
  generate
    for (t = 0; t < BIP_TMR_NUM; t++)
    begin : g_tmr
      localparam logic [7:0] OFF = 8'(BIP_OFF_TLOAD + t * BIP_TLOAD_STEP);
      wire wr_load = reg_wr_in && (reg_addr_in == OFF);

      always_ff @(posedge core_clk_in)
      begin
        if (!rst_n_in)
          tload_r[t] <= '0;
        else if (wr_load)
          tload_r[t] <= reg_wdata_in[BIP_TMR_W-1:0];
      end

      bip_timer #(
        .WIDTH(BIP_TMR_W),
        .PRESCALE(TMR_PRESCALE)
      ) u_timer (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .enable_in(tctl_r[t]),
        .load_in(tload_r[t]),
        .timeout_out(tmr_timeout[t])
      );

      assign tload_rd[t] = tload_r[t];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Edge latches and request grid

  // Latched edge sources: power fail, abort, parity, tick, subsystem edge
  logic pfail_r;
  logic abort_r;
  logic parity_r;
  logic tick_r;
  logic sub_edge_r;
  logic [BIP_SLOTS-1:0] req;

  // Acknowledge decode
  wire [BIP_SLOTS-1:0] ack_req = req & level_mask(iack_level_in);
  wire ack_hit = iack_in && (ack_req != '0);
  wire [5:0] ack_slot = top_slot(ack_req);
  wire clr_pfail = ack_hit && (int'(ack_slot) == BIP_S_PFAIL);
  wire clr_abort = ack_hit && (int'(ack_slot) == BIP_S_ABORT);
  wire clr_parity = ack_hit && (int'(ack_slot) == BIP_S_PARITY);
  wire clr_tick = ack_hit && ((int'(ack_slot) == BIP_S_TICK_HI) ||
                              (int'(ack_slot) == BIP_S_TICK_LO));
  wire clr_sub = ack_hit && (int'(ack_slot) == BIP_S_SUB_EDGE);

  // Set wins over acknowledge clear
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      pfail_r <= 1'b0;
      abort_r <= 1'b0;
      parity_r <= 1'b0;
      tick_r <= 1'b0;
      sub_edge_r <= 1'b0;
      pin_prev_r <= BIP_PIN_RST;
    end
    else
    begin
      pfail_r <= pfail_edge || (pfail_r && !clr_pfail);
      abort_r <= abort_edge || (abort_r && !clr_abort);
      parity_r <= parity_edge || (parity_r && !clr_parity);
      tick_r <= tick_edge || (tick_r && !clr_tick);
      sub_edge_r <= sub_edge || (sub_edge_r && !clr_sub);
      pin_prev_r <= pin_sync;
    end
  end

  // Fill the grid; unlisted slots, level 7 group 2 among them, stay low
  always_comb
  begin
    req = '0;
    for (int l = 1; l <= BIP_LEVELS; l++)
    begin
      req[bip_slot(l, 1)] = bus_level[l-1] &&
                            ctrl0_r[BIP_C0_BUS + l - 1];
    end
    req[BIP_S_PFAIL] = pfail_r && ctrl1_r[BIP_C1_PFAIL];
    req[BIP_S_ABORT] = abort_r && ctrl1_r[BIP_C1_ABORT];
    req[BIP_S_PARITY] = parity_r && ctrl1_r[BIP_C1_PARITY];
    req[BIP_S_TMR0] = status_r[BIP_ST_TMR] && ctrl0_r[BIP_C0_TMR];
    req[BIP_S_TMR1] = status_r[BIP_ST_TMR + 1] &&
                      ctrl0_r[BIP_C0_TMR + 1];
    req[BIP_S_TMR2] = status_r[BIP_ST_TMR + 2] &&
                      ctrl0_r[BIP_C0_TMR + 2];
    req[BIP_S_TICK_HI] = tick_r && ctrl0_r[BIP_C0_TICK] && tick_hi;
    req[BIP_S_TICK_LO] = tick_r && ctrl0_r[BIP_C0_TICK] && !tick_hi;
    req[BIP_S_SUB_EDGE] = sub_edge_r && ctrl0_r[BIP_C0_SUB_EDGE];
    req[BIP_S_SUB_LVL] = sub_level && ctrl0_r[BIP_C0_SUB_LVL];
    req[BIP_S_SERIAL] = serial_level && ctrl0_r[BIP_C0_SERIAL];
    if (!global_en)
      req = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Processor side

  logic [2:0] ipl_r;
  logic [7:0] vector_r;
  logic vector_valid_r;
  logic vector_external_r;

  wire any_req = (req != '0);
  wire [2:0] ipl_nxt = any_req ? slot_level(top_slot(req)) : 3'h0;
  wire [3:0] ack_nibble = ack_hit ? slot_nibble(ack_slot) : BIP_VN_SPURIOUS;

  // Level presentation and acknowledge answer
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      ipl_r <= 3'h0;
      vector_r <= 8'h00;
      vector_valid_r <= 1'b0;
      vector_external_r <= 1'b0;
    end
    else
    begin
      ipl_r <= ipl_nxt;
      vector_valid_r <= iack_in;
      if (iack_in)
      begin
        vector_r <= {vbase_r, ack_nibble};
        vector_external_r <= ack_hit && slot_external(ack_slot);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  logic [BIP_DATA_W-1:0] rd_mux;

  // Read selection, unmapped reads zero
  always_comb
  begin
    rd_mux = '0;
    unique case (reg_addr_in)
      BIP_OFF_CTRL0: rd_mux[BIP_C0_W-1:0] = ctrl0_r;
      BIP_OFF_CTRL1: rd_mux[BIP_C1_W-1:0] = ctrl1_r;
      BIP_OFF_VBASE: rd_mux[3:0] = vbase_r;
      BIP_OFF_STATUS: rd_mux[BIP_ST_W-1:0] = status_r;
      BIP_OFF_PEND: rd_mux[7:0] = {ipl_r, sub_edge_r, tick_r, parity_r,
                                   abort_r, pfail_r};
      BIP_OFF_TCTL: rd_mux[BIP_TMR_NUM-1:0] = tctl_r;
      default:
      begin
        for (int i = 0; i < BIP_TMR_NUM; i++)
        begin
          if (reg_addr_in == 8'(BIP_OFF_TLOAD + i * BIP_TLOAD_STEP))
            rd_mux[BIP_TMR_W-1:0] = tload_rd[i];
        end
      end
    endcase
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      rdata_r <= '0;
    else
      rdata_r <= reg_rd_in ? rd_mux : '0;
  end

  assign reg_rdata_out = rdata_r;
  assign ipl_out = ipl_r;
  assign vector_out = vector_r;
  assign vector_valid_out = vector_valid_r;
  assign vector_external_out = vector_external_r;

endmodule

// [testbench/bip_prioritizer_asserts.sv]
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Port-level checks of the acknowledge path and masking
module bip_prioritizer_asserts
  import bip_pkg::*;
#(
  parameter int unsigned TMR_PRESCALE = BIP_TMR_PRESCALE
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [BIP_ADDR_W-1:0] reg_addr_in,
  input wire logic [BIP_DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic iack_in,
  input wire logic [2:0] iack_level_in,
  input wire logic [2:0] ipl_out,
  input wire logic [7:0] vector_out,
  input wire logic vector_valid_out,
  input wire logic vector_external_out
);
  logic glob_r;
  logic [3:0] vbase_r;
  logic [3:0] nib;
  logic own;

  // Vector nibble of a locally supplied answer
  assign nib = vector_out[3:0];
  assign own = vector_valid_out && !vector_external_out;

  // Shadow of global enable and vector base
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      glob_r <= 1'b0;
      vbase_r <= BIP_VBASE_RST;
    end
    else if (reg_wr_in && reg_addr_in == BIP_OFF_CTRL1)
      glob_r <= reg_wdata_in[BIP_C1_GLOBAL];
    else if (reg_wr_in && reg_addr_in == BIP_OFF_VBASE)
      vbase_r <= reg_wdata_in[3:0];
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_valid_after_ack: assert property (iack_in |=> vector_valid_out)
    else $error("no vector after acknowledge");
  a_valid_needs_ack: assert property (!iack_in |=> !vector_valid_out)
    else $error("vector valid without acknowledge");
  a_vector_hold: assert property (
    !vector_valid_out |-> $stable(vector_out))
    else $error("vector changed between acknowledges");
  a_vbase_upper: assert property (own |-> vector_out[7:4] == vbase_r)
    else $error("vector upper nibble not programmed base");
  a_global_block: assert property (ipl_out != 3'd0 |-> $past(glob_r))
    else $error("level presented while globally masked");
  a_level7_nibble: assert property (
    own && nib inside {4'hb, 4'ha, 4'h8, 4'h0}
    |-> $past(iack_level_in) == 3'd7)
    else $error("level seven nibble on wrong level");
  a_level6_nibble: assert property (own && nib inside {4'h5, 4'h3, 4'h1}
    |-> $past(iack_level_in) == 3'd6)
    else $error("level six nibble on wrong level");
  a_level5_nibble: assert property (own && nib == 4'h2
    |-> $past(iack_level_in) == 3'd5)
    else $error("level five nibble on wrong level");
  a_level3_nibble: assert property (own && nib == 4'h7
    |-> $past(iack_level_in) == 3'd3)
    else $error("level three nibble on wrong level");

  // Main scenarios
  c_external: cover property (vector_valid_out && vector_external_out);
  c_top_level: cover property (ipl_out == 3'd7);
  c_tick_low: cover property (own && nib == 4'h7);
endmodule

bind bip_prioritizer bip_prioritizer_asserts #(.TMR_PRESCALE(TMR_PRESCALE))
  u_asserts (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .iack_in(iack_in), .iack_level_in(iack_level_in),
  .ipl_out(ipl_out), .vector_out(vector_out),
  .vector_valid_out(vector_valid_out),
  .vector_external_out(vector_external_out));

// [testbench/bip_cpu_model.sv]
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Processor side and the request sources around the handler
module bip_cpu_model
  import bip_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic vector_valid_in,
  input wire logic [7:0] vector_in,
  input wire logic vector_external_in,
  output logic iack_out,
  output logic [2:0] iack_level_out,
  output logic [BIP_PIN_W-1:0] pins_out
);
  // Sources idle, no acknowledge
  initial
  begin
    iack_out = 1'b0;
    iack_level_out = 3'd0;
    pins_out = BIP_PIN_RST;
  end

  // One source pin, held until changed again
  task automatic pin(input int idx, input logic val);
    @(posedge core_clk_in);
    pins_out[idx] <= val;
  endtask

  // One-cycle acknowledge, answer taken in the following cycle
  task automatic ack(input logic [2:0] lvl, output logic [8:0] res);
    @(posedge core_clk_in);
    iack_out <= 1'b1;
    iack_level_out <= lvl;
    @(posedge core_clk_in);
    iack_out <= 1'b0;
    #1;
    res = vector_valid_in ? {vector_external_in, vector_in} : 9'h1ff;
  endtask
endmodule

// [testbench/board_interrupt_prioritizer_tb.sv]
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the interrupt prioritizer
module board_interrupt_prioritizer_tb
  import bip_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic iack;
  logic [2:0] lvl;
  logic [2:0] ipl;
  logic [7:0] vec;
  logic vld;
  logic ext;
  logic [BIP_PIN_W-1:0] pins;
  int err_count = 0;
  int check_count = 0;

  always #25 clk = ~clk;

  bip_prioritizer uut (.core_clk_in(clk),
    .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .power_fail_n_in(pins[0]), .abort_n_in(pins[1]),
    .parity_error_request_in(pins[2]), .serial_output_bit_three_in(pins[3]),
    .subsystem_bus_request_n_in(pins[4]),
    .serial_controller_request_n_in(pins[5]),
    .bus_interrupt_n_in(pins[12:6]), .iack_in(iack), .iack_level_in(lvl),
    .ipl_out(ipl), .vector_out(vec), .vector_valid_out(vld),
    .vector_external_out(ext));

  bip_cpu_model cpu (.core_clk_in(clk), .vector_valid_in(vld),
    .vector_in(vec), .vector_external_in(ext), .iack_out(iack),
    .iack_level_out(lvl), .pins_out(pins));

  ////////////////////////////////////////////////////////////////////////////
  // Compare, bus cycles and acknowledge helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic ipl_chk(input logic [2:0] e);
    repeat (5) @(posedge clk);
    #1;
    chk({29'h0, ipl}, {29'h0, e});
  endtask
  task automatic ack_chk(input logic [2:0] l, input logic [8:0] e);
    logic [8:0] v;
    cpu.ack(l, v);
    chk({23'h0, v}, {23'h0, e});
  endtask
  task automatic ext_chk(input logic [2:0] l);
    logic [8:0] v;
    cpu.ack(l, v);
    chk({31'h0, v[8]}, 32'h1);
  endtask
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog against a hang
  initial
  begin
    #500000;
    err_count++;
    $display("watchdog expired");
    final_report;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(BIP_OFF_CTRL0, 32'h0);
    rd_chk(8'hfc, 32'h0);
    wr_reg(BIP_OFF_VBASE, 32'h4);
    wr_reg(BIP_OFF_CTRL1, 32'h1f);
    cpu.pin(1, 1'b0);
    cpu.pin(2, 1'b1);
    ipl_chk(3'd7);
    ack_chk(3'd7, 9'h04a);
    ack_chk(3'd7, 9'h048);
    ack_chk(3'd7, 9'h04f);
    cpu.pin(1, 1'b1);
    $display("priority test done");
    wr_reg(BIP_OFF_CTRL1, 32'h1b);
    wr_reg(BIP_OFF_STATUS, 32'h1);
    rd_chk(BIP_OFF_STATUS, 32'h0);
    cpu.pin(2, 1'b0);
    cpu.pin(2, 1'b1);
    ipl_chk(3'd0);
    rd_chk(BIP_OFF_STATUS, 32'h1);
    wr_reg(BIP_OFF_STATUS, 32'h1);
    rd_chk(BIP_OFF_STATUS, 32'h0);
    $display("parity test done");
    wr_reg(BIP_OFF_CTRL1, 32'h13);
    cpu.pin(0, 1'b0);
    cpu.pin(1, 1'b0);
    ipl_chk(3'd0);
    rd_chk(BIP_OFF_PEND, 32'h7);
    wr_reg(BIP_OFF_CTRL1, 32'h1b);
    ipl_chk(3'd7);
    ack_chk(3'd7, 9'h04b);
    ack_chk(3'd7, 9'h04a);
    cpu.pin(0, 1'b1);
    cpu.pin(1, 1'b1);
    ipl_chk(3'd0);
    $display("global mask test done");
    cpu.pin(3, 1'b0);
    ipl_chk(3'd0);
    wr_reg(BIP_OFF_CTRL0, 32'h1);
    ipl_chk(3'd6);
    ack_chk(3'd6, 9'h045);
    cpu.pin(3, 1'b1);
    wr_reg(BIP_OFF_CTRL1, 32'h0b);
    cpu.pin(3, 1'b0);
    ipl_chk(3'd3);
    ack_chk(3'd3, 9'h047);
    cpu.pin(3, 1'b1);
    $display("tick test done");
    wr_reg(BIP_OFF_CTRL0, 32'h2);
    cpu.pin(4, 1'b0);
    ipl_chk(3'd6);
    ack_chk(3'd6, 9'h043);
    ipl_chk(3'd0);
    wr_reg(BIP_OFF_CTRL0, 32'h4);
    ipl_chk(3'd4);
    ext_chk(3'd4);
    ipl_chk(3'd4);
    cpu.pin(4, 1'b1);
    ipl_chk(3'd0);
    wr_reg(BIP_OFF_CTRL0, 32'h8);
    cpu.pin(5, 1'b0);
    ipl_chk(3'd5);
    ext_chk(3'd5);
    cpu.pin(5, 1'b1);
    ipl_chk(3'd0);
    $display("level source test done");
    for (int l = 1; l <= 7; l++)
    begin
      wr_reg(BIP_OFF_CTRL0, 32'h1 << (7 + l));
      cpu.pin(5 + l, 1'b0);
      ipl_chk(3'(l));
      ext_chk(3'(l));
      cpu.pin(5 + l, 1'b1);
      ipl_chk(3'd0);
    end
    $display("bus level test done");
    for (int i = 0; i < 3; i++)
    begin
      wr_reg(BIP_OFF_CTRL0, 32'h10 << i);
      wr_reg(8'(BIP_OFF_TLOAD + BIP_TLOAD_STEP * i), 32'h3);
      wr_reg(BIP_OFF_TCTL, 32'h1 << i);
      rd_chk(BIP_OFF_STATUS, 32'h0);
      // Time-out after four prescaled steps of sixteen clocks each
      repeat (61) @(posedge clk);
      rd_chk(BIP_OFF_STATUS, 32'h0);
      rd_chk(BIP_OFF_STATUS, 32'h2 << i);
      wr_reg(BIP_OFF_TCTL, 32'h0);
      rd_chk(BIP_OFF_STATUS, 32'h2 << i);
      ipl_chk(3'(7 - i));
      ack_chk(3'(7 - i), 9'(32'h40 + i));
      ipl_chk(3'(7 - i));
      wr_reg(BIP_OFF_STATUS, 32'h2 << i);
      ipl_chk(3'd0);
    end
    $display("timer test done");
    final_report;
  end
endmodule
